/* hw/cpktr_regs.sv */
// channel peak tracking register bank with apb slave
// Functional notes
// R1 - each maximum register holds the highest code seen since its last read
// R2 - reading a maximum register returns it, then clears it to zero
// R3 - each minimum register holds the lowest code seen since its last read
// R4 - reading a minimum register returns it, then sets it to 0xFF
// R5 - maximum bytes reset to zero; eight bits wide, read only
// R6 - minimum bytes reset to 0xFF; eight bits wide, read only
// R7 - channel 6 and 7 maxima sit at 0x6C/0x6D and 0x6E/0x6F
// R8 - channel 0 minimum at 0x80/0x81, channel 1 low byte at 0x82
// R9 - each finished conversion on channel 0, 1, 6 or 7 updates that channel's extreme pair when exceeded
`timescale 1ns/1ps

`include "cpktr_defs.svh"

module cpktr_regs
  import cpktr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CODE_W = 12
)
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESETN,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic                   PREADY,
  output logic      [31:0]       PRDATA,
  output logic                   PSLVERR,
  // finished conversions
  input  wire logic              CONV_VALID,
  input  wire logic [2:0]        CONV_CHANNEL,
  input  wire logic [CODE_W-1:0] CONV_CODE
);

  // =====================================================================
  // parameter checks
  if (ADDR_W < (`CPKTR_IDX_W + `CPKTR_IDX_SHIFT))
  begin : g_bad_addr
    $error("address bus too narrow for the register map");
  end

  if ((CODE_W < 1) || (CODE_W > `CPKTR_VAL_W))
  begin : g_bad_code
    $error("conversion code wider than the byte pair");
  end

  // =====================================================================
  // functions
  function automatic logic [`CPKTR_VAL_W-1:0] to_value(input logic [CODE_W-1:0] code);
    logic [`CPKTR_VAL_W-1:0] wide;
    wide = `CPKTR_VAL_W'(code);
    to_value = wide << (`CPKTR_VAL_W - CODE_W);
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [`CPKTR_IDX_W-1:0] idx);
    byte_addr = ADDR_W'(idx) << `CPKTR_IDX_SHIFT;
  endfunction

  function automatic cpktr_sel_t decode(input logic [ADDR_W-1:0] addr);
    decode = CPKTR_SEL_NONE;
    // R7 - maxima of channels 6 and 7
    if (addr == byte_addr(`CPKTR_IDX_HI6_LOW))
      decode = CPKTR_SEL_HI6_LOW;
    else if (addr == byte_addr(`CPKTR_IDX_HI6_HIGH))
      decode = CPKTR_SEL_HI6_HIGH;
    else if (addr == byte_addr(`CPKTR_IDX_HI7_LOW))
      decode = CPKTR_SEL_HI7_LOW;
    else if (addr == byte_addr(`CPKTR_IDX_HI7_HIGH))
      decode = CPKTR_SEL_HI7_HIGH;
    // R8 - minima of channels 0 and 1
    else if (addr == byte_addr(`CPKTR_IDX_LO0_LOW))
      decode = CPKTR_SEL_LO0_LOW;
    else if (addr == byte_addr(`CPKTR_IDX_LO0_HIGH))
      decode = CPKTR_SEL_LO0_HIGH;
    else if (addr == byte_addr(`CPKTR_IDX_LO1_LOW))
      decode = CPKTR_SEL_LO1_LOW;
  endfunction

  function automatic logic for_channel(input logic valid, input logic [2:0] ch, input logic [2:0] want);
    for_channel = valid && (ch == want);
  endfunction

  // =====================================================================
  // signals
  cpktr_state_t            state;
  cpktr_state_t            next_state;
  cpktr_sel_t              sel;
  logic                    access;
  logic                    rd_take;
  logic                    bad_take;
  logic                    sample_valid;
  logic [2:0]              sample_channel;
  logic [`CPKTR_VAL_W-1:0] sample_value;
  logic [7:0]              hi6_low;
  logic [7:0]              hi6_high;
  logic [7:0]              hi7_low;
  logic [7:0]              hi7_high;
  logic [7:0]              lo0_low;
  logic [7:0]              lo0_high;
  logic [7:0]              lo1_low;
  logic [7:0]              lo1_high_hidden;
  logic [7:0]              next_rdata;

  // =====================================================================
  // conversion capture
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sample_valid   <= 1'b0;
      sample_channel <= 3'h0;
      sample_value   <= `CPKTR_VAL_W'(0);
    end
    else
    begin
      sample_valid   <= CONV_VALID;
      sample_channel <= CONV_CHANNEL;
      sample_value   <= to_value(CONV_CODE);
    end
  end

  // =====================================================================
  // access decode
  assign sel      = decode(PADDR);
  assign access   = PSEL && PENABLE && (state == CPKTR_IDLE);
  assign rd_take  = access && !PWRITE && (sel != CPKTR_SEL_NONE);
  assign bad_take = access && (PWRITE || (sel == CPKTR_SEL_NONE));

  // =====================================================================
  // trackers
  // R1 R2 - channel 6 maximum
  cpktr_track #(.IS_MIN(1'b0), .VAL_W(`CPKTR_VAL_W)) u_hi6
  (
    .clk          (CLK),
    .resetn       (RESETN),
    .sample_valid (for_channel(sample_valid, sample_channel, `CPKTR_CH_HI6)),
    .sample_value (sample_value),
    .clear_low    (rd_take && (sel == CPKTR_SEL_HI6_LOW)),
    .clear_high   (rd_take && (sel == CPKTR_SEL_HI6_HIGH)),
    .low_byte     (hi6_low),
    .high_byte    (hi6_high)
  );

  // R1 R2 - channel 7 maximum
  cpktr_track #(.IS_MIN(1'b0), .VAL_W(`CPKTR_VAL_W)) u_hi7
  (
    .clk          (CLK),
    .resetn       (RESETN),
    .sample_valid (for_channel(sample_valid, sample_channel, `CPKTR_CH_HI7)),
    .sample_value (sample_value),
    .clear_low    (rd_take && (sel == CPKTR_SEL_HI7_LOW)),
    .clear_high   (rd_take && (sel == CPKTR_SEL_HI7_HIGH)),
    .low_byte     (hi7_low),
    .high_byte    (hi7_high)
  );

  // R3 R4 - channel 0 minimum
  cpktr_track #(.IS_MIN(1'b1), .VAL_W(`CPKTR_VAL_W)) u_lo0
  (
    .clk          (CLK),
    .resetn       (RESETN),
    .sample_valid (for_channel(sample_valid, sample_channel, `CPKTR_CH_LO0)),
    .sample_value (sample_value),
    .clear_low    (rd_take && (sel == CPKTR_SEL_LO0_LOW)),
    .clear_high   (rd_take && (sel == CPKTR_SEL_LO0_HIGH)),
    .low_byte     (lo0_low),
    .high_byte    (lo0_high)
  );

  // R3 R4 - channel 1 minimum, high byte kept for comparison
  cpktr_track #(.IS_MIN(1'b1), .VAL_W(`CPKTR_VAL_W)) u_lo1
  (
    .clk          (CLK),
    .resetn       (RESETN),
    .sample_valid (for_channel(sample_valid, sample_channel, `CPKTR_CH_LO1)),
    .sample_value (sample_value),
    .clear_low    (rd_take && (sel == CPKTR_SEL_LO1_LOW)),
    .clear_high   (rd_take && (sel == CPKTR_SEL_LO1_LOW)),
    .low_byte     (lo1_low),
    .high_byte    (lo1_high_hidden)
  );

  // =====================================================================
  // read multiplexer
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (sel)
      CPKTR_SEL_NONE:
        next_rdata = 8'h00;
      CPKTR_SEL_HI6_LOW:
        next_rdata = hi6_low;
      CPKTR_SEL_HI6_HIGH:
        next_rdata = hi6_high;
      CPKTR_SEL_HI7_LOW:
        next_rdata = hi7_low;
      CPKTR_SEL_HI7_HIGH:
        next_rdata = hi7_high;
      CPKTR_SEL_LO0_LOW:
        next_rdata = lo0_low;
      CPKTR_SEL_LO0_HIGH:
        next_rdata = lo0_high;
      CPKTR_SEL_LO1_LOW:
        next_rdata = lo1_low;
    endcase
  end

  // =====================================================================
  // slave state machine
  always_comb
  begin
    next_state = state;
    unique case (state)
      CPKTR_IDLE:
      begin
        if (rd_take)
          next_state = CPKTR_RESP;
        else if (bad_take)
          next_state = CPKTR_ERR;
      end
      CPKTR_RESP:
        next_state = CPKTR_IDLE;
      CPKTR_ERR:
        next_state = CPKTR_IDLE;
      default:
        next_state = CPKTR_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      state <= CPKTR_IDLE;
    else
      state <= next_state;
  end

  // =====================================================================
  // bus outputs
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      PREADY <= 1'b0;
    else
      PREADY <= rd_take || bad_take;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      PSLVERR <= 1'b0;
    else
      PSLVERR <= bad_take;
  end

  // R5 R6 - bytes sit low, upper bits zero
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= `CPKTR_DATA_W'(0);
    else if (rd_take)
      PRDATA <= `CPKTR_DATA_W'(next_rdata);
    else if (bad_take)
      PRDATA <= `CPKTR_DATA_W'(0);
  end

endmodule

/* hw/cpktr_defs.svh */
// constants for the channel peak tracking register bank
`ifndef CPKTR_DEFS_SVH
`define CPKTR_DEFS_SVH

// =====================================================================
// register indices, byte address is four times the index
`define CPKTR_IDX_HI6_LOW   8'h6C
`define CPKTR_IDX_HI6_HIGH  8'h6D
`define CPKTR_IDX_HI7_LOW   8'h6E
`define CPKTR_IDX_HI7_HIGH  8'h6F
`define CPKTR_IDX_LO0_LOW   8'h80
`define CPKTR_IDX_LO0_HIGH  8'h81
`define CPKTR_IDX_LO1_LOW   8'h82

// =====================================================================
// byte address layout
`define CPKTR_IDX_SHIFT     2
`define CPKTR_IDX_W         8
`define CPKTR_LANE_BITS     2'h0

// =====================================================================
// reset and restart values
`define CPKTR_MAX_RST       8'h00
`define CPKTR_MIN_RST       8'hFF

// =====================================================================
// tracked channels
`define CPKTR_CH_HI6        3'h6
`define CPKTR_CH_HI7        3'h7
`define CPKTR_CH_LO0        3'h0
`define CPKTR_CH_LO1        3'h1

// =====================================================================
// data widths
`define CPKTR_BYTE_W        8
`define CPKTR_VAL_W         16
`define CPKTR_DATA_W        32

`endif

/* hw/cpktr_pkg.sv */
// types for the channel peak tracking register bank
package cpktr_pkg;

  // =====================================================================
  // bus slave states
  typedef enum logic [2:0]
  {
    CPKTR_IDLE = 3'b001,
    CPKTR_RESP = 3'b010,
    CPKTR_ERR  = 3'b100
  } cpktr_state_t;

  // =====================================================================
  // register selection
  typedef enum logic [2:0]
  {
    CPKTR_SEL_NONE    = 3'h0,
    CPKTR_SEL_HI6_LOW = 3'h1,
    CPKTR_SEL_HI6_HIGH= 3'h2,
    CPKTR_SEL_HI7_LOW = 3'h3,
    CPKTR_SEL_HI7_HIGH= 3'h4,
    CPKTR_SEL_LO0_LOW = 3'h5,
    CPKTR_SEL_LO0_HIGH= 3'h6,
    CPKTR_SEL_LO1_LOW = 3'h7
  } cpktr_sel_t;

endpackage

/* hw/cpktr_track.sv */
// one extreme tracker holding a low and a high byte
`timescale 1ns/1ps

`include "cpktr_defs.svh"

module cpktr_track
  import cpktr_pkg::*;
#(
  parameter bit IS_MIN = 1'b0,
  parameter int VAL_W  = 16
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // new sample for this channel
  input  wire logic             sample_valid,
  input  wire logic [VAL_W-1:0] sample_value,
  // read restarts
  input  wire logic             clear_low,
  input  wire logic             clear_high,
  // stored bytes
  output logic      [7:0]       low_byte,
  output logic      [7:0]       high_byte
);

  localparam logic [7:0] RST_VAL = IS_MIN ? `CPKTR_MIN_RST : `CPKTR_MAX_RST;

  // =====================================================================
  // parameter check
  if (VAL_W != `CPKTR_VAL_W)
  begin : g_bad_width
    $error("tracker value width must be two bytes");
  end

  // =====================================================================
  // comparison
  function automatic logic beyond(input logic [VAL_W-1:0] value, input logic [VAL_W-1:0] stored);
    beyond = IS_MIN ? (value < stored) : (value > stored);
  endfunction

  logic take;

  // R9 - compare new code
  assign take = sample_valid && beyond(sample_value, {high_byte, low_byte});

  // =====================================================================
  // low byte
  always_ff @(posedge clk or negedge resetn)
  begin
    // R5 R6 - reset value
    if (!resetn)
      low_byte <= RST_VAL;
    // R1 R3 - new extreme wins
    else if (take)
      low_byte <= sample_value[7:0];
    // R2 R4 - read restarts
    else if (clear_low)
      low_byte <= RST_VAL;
  end

  // =====================================================================
  // high byte
  always_ff @(posedge clk or negedge resetn)
  begin
    // R5 R6 - reset value
    if (!resetn)
      high_byte <= RST_VAL;
    // R1 R3 - new extreme wins
    else if (take)
      high_byte <= sample_value[VAL_W-1:`CPKTR_BYTE_W];
    // R2 R4 - read restarts
    else if (clear_high)
      high_byte <= RST_VAL;
  end

endmodule

/* hw/cpktr_placeholder_none.sv */
// intentionally empty compile unit
`timescale 1ns/1ps

/* tb/cpktr_assertions.sv */
// checker for the channel peak tracking register bank
`timescale 1ns/1ps

module cpktr_assertions
  import cpktr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CODE_W = 12
)
(
  // clock and reset
  input wire logic              CLK,
  input wire logic              RESETN,
  // apb
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic              PREADY,
  input wire logic [31:0]       PRDATA,
  input wire logic              PSLVERR,
  // conversions
  input wire logic              CONV_VALID,
  input wire logic [2:0]        CONV_CHANNEL,
  input wire logic [CODE_W-1:0] CONV_CODE
);
  // ====================================================================
  // helpers
  logic mapped;
  logic rd_ok;
  assign mapped = PADDR[1:0] == 2'h0 && (PADDR >> 2) inside {[8'h6C:8'h6F], [8'h80:8'h82]};
  assign rd_ok  = PSEL && PENABLE && PREADY && !PWRITE && !PSLVERR;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // ====================================================================
  // properties
  sequence s_reread;
    rd_ok && !CONV_VALID && !$past(CONV_VALID) && !$past(CONV_VALID, 2)
      ##1 !CONV_VALID [*2] ##1 rd_ok && PADDR == $past(PADDR, 3);
  endsequence
  property p_wait;     PSEL && $rose(PENABLE) |=> PREADY; endproperty
  property p_pulse;    PREADY |=> !PREADY; endproperty
  property p_wr_err;   PREADY && PWRITE |-> PSLVERR; endproperty
  property p_map;      PREADY && !PWRITE |-> PSLVERR == !mapped; endproperty
  property p_err_zero; PREADY && PSLVERR |-> PRDATA == 32'h0; endproperty
  property p_upper;    PREADY |-> PRDATA[31:8] == 24'h0; endproperty
  property p_hold;     $changed(PRDATA) |-> PREADY; endproperty
  property p_max_clr;  s_reread ##0 PADDR < 12'h200 |-> PRDATA == 32'h0; endproperty
  property p_min_set;  s_reread ##0 PADDR >= 12'h200 |-> PRDATA == 32'hFF; endproperty

  a_wait: assert property (p_wait) else $error("ready late");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_wr_err: assert property (p_wr_err) else $error("write accepted");
  a_map: assert property (p_map) else $error("map error flag");
  a_err_zero: assert property (p_err_zero) else $error("error data not zero");
  a_upper: assert property (p_upper) else $error("upper data bits set");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_max_clr: assert property (p_max_clr) else $error("maximum not cleared");
  a_min_set: assert property (p_min_set) else $error("minimum not restarted");
endmodule

bind cpktr_regs cpktr_assertions #(.ADDR_W(ADDR_W), .CODE_W(CODE_W)) u_chk (.CLK(CLK), .RESETN(RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .CONV_VALID(CONV_VALID), .CONV_CHANNEL(CONV_CHANNEL), .CONV_CODE(CONV_CODE));

/* tb/cpktr_host.sv */
// host model issuing apb transfers
`timescale 1ns/1ps

module cpktr_host
(
  // clock
  input wire logic        clk,
  // apb master side
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [11:0]     paddr,
  output logic [31:0]     pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h0;
    pwdata  = 32'h0;
  end

  // one transfer; hold keeps select up for a following setup
  task automatic xfer(input logic [11:0] a, input logic w, input bit hold,
                      output logic [31:0] d, output logic e, output bit ok);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {4{a[7:0]}};
    @(posedge clk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++)
    begin
      @(posedge clk);
      ok = pready;
    end
    d = prdata;
    e = pslverr;
    penable <= 1'b0;
    if (!hold)
    begin
      psel  <= 1'b0;
      paddr <= ~a;
      @(posedge clk);
    end
  endtask
endmodule

/* tb/tb.sv */
// testbench for the channel peak tracking register bank
`timescale 1ns/1ps

module tb
  import cpktr_pkg::*;
;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        CONV_VALID = 1'b0;
  logic [2:0]  CONV_CHANNEL = 3'h0;
  logic [11:0] CONV_CODE = 12'h000;
  int          error_cnt = 0;
  int          checks = 0;
  logic [11:0] addr [7] = '{12'h1B0, 12'h1B4, 12'h1B8, 12'h1BC, 12'h200, 12'h204, 12'h208};
  logic [7:0]  rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  trk_v [7] = '{8'hF0, 8'h7F, 8'hC0, 8'hAB, 8'h00, 8'h0F, 8'h50};
  logic [14:0] cv_t [11] = '{15'h6123, 15'h67FF, 15'h6456, 15'h7ABC, 15'h0321, 15'h00F0, 15'h0FFF,
                             15'h1005, 15'h1100, 15'h2000, 15'h3FFF};

  cpktr_regs #(.ADDR_W(12), .CODE_W(12)) dut (.CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .CONV_VALID(CONV_VALID), .CONV_CHANNEL(CONV_CHANNEL), .CONV_CODE(CONV_CODE));
  cpktr_host host (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR));

  always #12.5 CLK = ~CLK;

  // ====================================================================
  // tasks
  task automatic close_out();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [11:0] a, input logic w, input bit hold, input logic [31:0] xd, input logic xe);
    logic [31:0] d;
    logic        e;
    bit          ok;
    host.xfer(a, w, hold, d, e, ok);
    if (!ok)
    begin
      error_cnt++;
      close_out();
    end
    else
    begin
      chk(d, xd);
      chk({31'h0, e}, {31'h0, xe});
    end
  endtask

  task automatic conv(input logic [14:0] c, input bit last);
    CONV_VALID   <= 1'b1;
    CONV_CHANNEL <= c[14:12];
    CONV_CODE    <= c[11:0];
    @(posedge CLK);
    if (last)
      CONV_VALID <= 1'b0;
  endtask

  // ====================================================================
  // sequence
  initial
  begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      acc(addr[i], 1'b0, 1'b1, {24'h0, rst_v[i]}, 1'b0);
      acc(addr[i], 1'b0, i < 6, {24'h0, rst_v[i]}, 1'b0);
    end
    for (int i = 0; i < 11; i++)
      conv(cv_t[i], i == 10);
    for (int i = 0; i < 7; i++)
    begin
      acc(addr[i], 1'b0, 1'b1, {24'h0, trk_v[i]}, 1'b0);
      acc(addr[i], 1'b0, i < 6, {24'h0, rst_v[i]}, 1'b0);
    end
    conv(15'h6100, 1'b0);
    conv(15'h0E00, 1'b1);
    acc(12'h1B4, 1'b0, 1'b1, 32'h10, 1'b0);
    acc(12'h204, 1'b0, 1'b0, 32'hE0, 1'b0);
    acc(12'h1B0, 1'b1, 1'b1, 32'h0, 1'b1);
    acc(12'h1C0, 1'b0, 1'b1, 32'h0, 1'b1);
    acc(12'h1B1, 1'b0, 1'b1, 32'h0, 1'b1);
    acc(12'h20C, 1'b0, 1'b1, 32'h0, 1'b1);
    acc(12'h1B0, 1'b0, 1'b0, 32'h0, 1'b0);
    conv(15'h7FFF, 1'b1);
    repeat (2) @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    acc(12'h1BC, 1'b0, 1'b0, 32'h0, 1'b0);
    acc(12'h200, 1'b0, 1'b0, 32'hFF, 1'b0);
    close_out();
  end
endmodule
